// [hw/rpad_initiator.sv]
`timescale 1ns/1ns
`default_nettype none
`include "rpad_defines.svh"
module rpad_initiator
  import rpad_pkg::*;
#(
  parameter int TAGS = 8
)
(
  input wire logic clk, // Bus clock
  input wire logic reset_n, // Synchronous reset
  input wire logic req_valid, // Request offered
  input wire rpad_req_t req, // Request content, true polarity
  output logic req_ready, // Request accepted this cycle
  output logic request_strobe_n, // Strobe, active low
  output rpad_pins_t pins_out, // Address and parity, active low
  output logic addr_oe, // Driving the address lines
  input wire rpad_pins_t pins_in, // Address lines as seen on the bus
  input wire logic bus_strobe_n, // Strobe from any agent
  input wire logic [4:0] bus_req_type, // First-clock request type, true polarity
  output logic [32:0] power_on_config, // Lines caught at reset release
  output logic snoop_start, // Memory request observed
  output logic [32:0] snoop_addr, // Its byte address bits 35..3
  output logic [1:0] critical_word, // Its first chunk
  output logic io_seen, // I/O request observed
  output logic [13:0] io_addr, // Its I/O address bits 16..3
  output logic reply_match, // Deferred reply matched a sent tag
  output logic [7:0] reply_tag, // Tag of the last reply
  output logic parity_error // Parity mismatch on either request clock
);
  typedef enum logic [1:0] {ST_IDLE, ST_SECOND, ST_GAP} rpad_state_t;
  rpad_state_t state;
  rpad_req_t held;
  logic [1:0] gap;
  logic prev_reset_n;
  logic seen_first;
  logic [4:0] seen_type;
  logic table_hit;
  logic table_full;
  logic accept;
  logic [32:0] bus_addr;
  logic obs_lookup;

  // Parity true when an even number of covered active-low lines are low
  function automatic logic even_low(input logic [32:0] lines, input logic upper);
    logic [32:0] mask;
    mask = '0;
    for (int i = 0; i < `RPAD_ADDR_W; i++)
    begin
      mask[i] = upper ? (i >= `RPAD_UPPER_LO) : (i <= `RPAD_LOWER_HI);
    end
    return ~^(~lines & mask);
  endfunction

  function automatic rpad_kind_t decode_kind(input logic [4:0] t);
    if (t == `RPAD_REQ_DEFER)
      return RPAD_DEFER;
    else if ((t & `RPAD_REQ_IO_MASK) == `RPAD_REQ_IO)
      return RPAD_IO;
    else if (t == `RPAD_REQ_BTM)
      return RPAD_BTM;
    else if (t == `RPAD_REQ_SPECIAL)
      return RPAD_SPECIAL;
    else if (t[`RPAD_MEM_HI:`RPAD_MEM_LO] != 2'h0)
      return RPAD_MEM;
    else
      return RPAD_OTHER;
  endfunction

  // First-clock address shaped per type; reserved bits driven inactive
  function automatic logic [32:0] first_word(input rpad_req_t r);
    logic [32:0] a;
    a = '0;
    unique case (decode_kind(r.req_type))
      RPAD_MEM: a = r.first_addr;
      RPAD_IO: a[`RPAD_IO_HI:0] = r.first_addr[`RPAD_IO_HI:0];
      RPAD_DEFER: a[`RPAD_DID_LO+7:`RPAD_DID_LO] = r.deferred_tag;
      RPAD_BTM, RPAD_SPECIAL, RPAD_OTHER: a = '0;
    endcase
    return a;
  endfunction

  function automatic logic [32:0] second_word(input rpad_req_t r);
    return {4'h0, r.req_attributes, r.deferred_tag, r.byte_lane_enables, r.extended_function};
  endfunction

  function automatic rpad_pins_t to_pins(input logic [32:0] a);
    rpad_pins_t p;
    p.addr_n = ~a;
    p.upper_addr_parity = even_low(~a, 1'b1);
    p.lower_addr_parity = even_low(~a, 1'b0);
    return p;
  endfunction

  // Deferrable requests need a free tag slot, so refuse them while full
  assign accept = state == ST_IDLE && req_valid && reset_n
    && !(table_full && decode_kind(req.req_type) != RPAD_DEFER);
  assign bus_addr = ~pins_in.addr_n;
  // Match runs one clock late on the tag caught in the first clock;
  // the second clock carries the replier's own tag field, not ours
  assign obs_lookup = seen_first && decode_kind(seen_type) == RPAD_DEFER;

  rpad_tag_table #(.DEPTH(TAGS)) u_tags
  (
    .clk(clk),
    .reset_n(reset_n),
    .alloc(accept && decode_kind(req.req_type) != RPAD_DEFER),
    .alloc_tag(req.deferred_tag),
    .lookup(obs_lookup),
    .lookup_tag(reply_tag),
    .hit(table_hit),
    .full(table_full)
  );

  // Two request clocks then a two-clock gap: a new take at most every four clocks
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      gap <= 2'h0;
      held <= '0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
          if (accept)
          begin
            held <= req;
            state <= ST_SECOND;
          end
        ST_SECOND:
        begin
          state <= ST_GAP;
          gap <= `RPAD_ISSUE_GAP - 2'h1;
        end
        ST_GAP:
          if (gap == 2'h0)
            state <= ST_IDLE;
          else
            gap <= gap - 2'h1;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      request_strobe_n <= 1'b1;
      pins_out <= to_pins('0);
      addr_oe <= 1'b0;
      req_ready <= 1'b0;
    end
    else
    begin
      req_ready <= accept;
      request_strobe_n <= !accept;
      if (accept)
      begin
        pins_out <= to_pins(first_word(req));
        addr_oe <= 1'b1;
      end
      else if (state == ST_SECOND)
      begin
        pins_out <= to_pins(second_word(held));
        addr_oe <= 1'b1;
      end
      else
      begin
        addr_oe <= 1'b0;
      end
    end
  end

  // Configuration caught on the first clock after reset is released
  always_ff @(posedge clk)
  begin
    prev_reset_n <= reset_n;
    if (!reset_n)
    begin
      power_on_config <= '0;
    end
    else if (!prev_reset_n)
    begin
      power_on_config <= bus_addr;
    end
  end

  // Observer of every request on the bus, including our own
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      seen_first <= 1'b0;
      seen_type <= `RPAD_REQ_ZERO;
      snoop_start <= 1'b0;
      snoop_addr <= '0;
      critical_word <= 2'h0;
      io_seen <= 1'b0;
      io_addr <= '0;
      reply_match <= 1'b0;
      reply_tag <= 8'h00;
      parity_error <= 1'b0;
    end
    else
    begin
      seen_first <= !bus_strobe_n;
      seen_type <= bus_req_type;
      snoop_start <= 1'b0;
      io_seen <= 1'b0;
      reply_match <= 1'b0;
      parity_error <= (!bus_strobe_n || seen_first)
        && (pins_in.upper_addr_parity != even_low(pins_in.addr_n, 1'b1)
        || pins_in.lower_addr_parity != even_low(pins_in.addr_n, 1'b0));
      if (!bus_strobe_n)
      begin
        unique case (decode_kind(bus_req_type))
          RPAD_MEM:
          begin
            snoop_start <= 1'b1;
            snoop_addr <= bus_addr;
            critical_word <= bus_addr[`RPAD_CWORD_HI:0];
          end
          RPAD_IO:
          begin
            io_seen <= 1'b1;
            io_addr <= bus_addr[`RPAD_IO_HI:0];
          end
          RPAD_DEFER:
            reply_tag <= bus_addr[`RPAD_DID_LO+7:`RPAD_DID_LO];
          RPAD_BTM, RPAD_SPECIAL, RPAD_OTHER: ;
        endcase
      end
      if (obs_lookup)
        reply_match <= table_hit;
    end
  end
endmodule
`default_nettype wire

// [hw/rpad_defines.svh]
// Function
// - Initiator drives address on both request clocks, different meaning each clock.
// - Upper parity covers address bits 35..24, lower parity covers bits 23..3.
// - Memory request types carry a 36-bit physical byte address.
// - Address bits 4..3 pick the critical word; burst moves the other three.
// - I/O request type carries the I/O address on bits 16..3 only.
// - I/O requests drive bits 35..17 zero; bit 16 only at range top.
// - Deferred reply carries deferred tag on first-clock bits 23..16.
// - Deferred reply bits 35..24 and 15..3 are reserved.
// - Branch-trace and special requests leave the whole first-clock address reserved.
// - Second-clock fields mean the same for every transaction type.
// - Second clock: attributes 31..24, tag 23..16, byte enables 15..8, function 7..3.
// - Address lines are sampled at reset release for power-on configuration.
// - Parity bit high when an even number of covered lines are low.
// - Strobe pulses for one clock; inactive during the second request clock.
`ifndef RPAD_DEFINES_SVH
`define RPAD_DEFINES_SVH
`define RPAD_ADDR_W 33
`define RPAD_UPPER_HI 32
`define RPAD_UPPER_LO 21
`define RPAD_LOWER_HI 20
`define RPAD_IO_HI 13
`define RPAD_IO_W 14
`define RPAD_IO_TOP_BIT 13
`define RPAD_DID_LO 13
`define RPAD_CWORD_HI 1
`define RPAD_MEM_HI 2
`define RPAD_MEM_LO 1
`define RPAD_REQ_IO 5'h10
`define RPAD_REQ_IO_MASK 5'h1e
`define RPAD_REQ_DEFER 5'h00
`define RPAD_REQ_BTM 5'h09
`define RPAD_REQ_SPECIAL 5'h08
`define RPAD_REQ_ZERO 5'h00
`define RPAD_ISSUE_GAP 2'h2
`endif

// [hw/rpad_pkg.sv]
package rpad_pkg;
  typedef enum logic [2:0] {RPAD_MEM, RPAD_IO, RPAD_DEFER, RPAD_BTM, RPAD_SPECIAL, RPAD_OTHER} rpad_kind_t;
  typedef struct packed {
    logic [4:0] req_type;
    logic [32:0] first_addr;
    logic [7:0] req_attributes;
    logic [7:0] deferred_tag;
    logic [7:0] byte_lane_enables;
    logic [4:0] extended_function;
  } rpad_req_t;
  typedef struct packed {
    logic [32:0] addr_n;
    logic upper_addr_parity;
    logic lower_addr_parity;
  } rpad_pins_t;
endpackage

// [hw/rpad_tag_table.sv]
`timescale 1ns/1ns
`default_nettype none
module rpad_tag_table
#(
  parameter int DEPTH = 8
)
(
  input wire logic clk, // Bus clock
  input wire logic reset_n, // Synchronous reset
  input wire logic alloc, // Record a sent tag
  input wire logic [7:0] alloc_tag, // Tag being sent
  input wire logic lookup, // Deferred reply seen
  input wire logic [7:0] lookup_tag, // Tag from the reply
  output logic hit, // Reply matched an entry
  output logic full // No free entry
);
  logic [DEPTH-1:0] valid;
  logic [7:0] tag [DEPTH];
  logic [DEPTH-1:0] match;
  logic [DEPTH-1:0] free_one;

  always_comb
  begin
    match = '0;
    free_one = '0;
    for (int i = 0; i < DEPTH; i++)
    begin
      match[i] = valid[i] && tag[i] == lookup_tag;
    end
    for (int i = DEPTH - 1; i >= 0; i--)
    begin
      if (!valid[i])
      begin
        free_one = '0;
        free_one[i] = 1'b1;
      end
    end
  end

  assign hit = lookup && (match != '0);
  assign full = &valid;

  // Entry stays until its reply retires it
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      valid <= '0;
    end
    else
    begin
      valid <= (valid & ~(lookup ? match : '0)) | ((alloc && !full) ? free_one : '0);
    end
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      if (alloc && !full && free_one[i])
      begin
        tag[i] <= alloc_tag;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/rpad_initiator_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module rpad_initiator_properties
  import rpad_pkg::*;
(
  input wire logic clk, // clock
  input wire logic reset_n, // reset
  input wire rpad_req_t req, // request
  input wire logic req_ready, // taken
  input wire logic request_strobe_n, // strobe
  input wire rpad_pins_t pins_out, // lines out
  input wire logic addr_oe, // driving
  input wire rpad_pins_t pins_in, // lines in
  input wire logic bus_strobe_n, // bus strobe
  input wire logic [4:0] bus_req_type, // bus type
  input wire logic [32:0] power_on_config, // config
  input wire logic snoop_start, // snoop
  input wire logic [32:0] snoop_addr // snoop address
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire go = !request_strobe_n;
  chk_strobe_single: assert property ($fell(request_strobe_n) |=> request_strobe_n)
    else $error("strobe longer than one clock");
  chk_strobe_ready: assert property (go |-> req_ready && addr_oe)
    else $error("strobe without ready or drive");
  chk_drive_two: assert property (go |=> addr_oe ##1 !addr_oe)
    else $error("address not driven for two clocks");
  chk_upper_par: assert property (addr_oe |-> pins_out.upper_addr_parity == ~^(~pins_out.addr_n[32:21]))
    else $error("upper parity wrong");
  chk_lower_par: assert property (addr_oe |-> pins_out.lower_addr_parity == ~^(~pins_out.addr_n[20:0]))
    else $error("lower parity wrong");
  chk_io_high_zero: assert property (go && req.req_type[4:1] == 4'h8 |-> &pins_out.addr_n[32:14])
    else $error("io upper bits not zero");
  chk_reply_reserved: assert property (go && req.req_type == 5'h00 |-> &pins_out.addr_n[32:21] && &pins_out.addr_n[12:0])
    else $error("reply reserved bits driven");
  chk_trace_reserved: assert property (go && req.req_type[4:1] == 4'h4 |-> &pins_out.addr_n)
    else $error("reserved address driven");
  chk_second_word: assert property (go |=> pins_out.addr_n == ~{4'h0, $past(req.req_attributes),
    $past(req.deferred_tag), $past(req.byte_lane_enables), $past(req.extended_function)})
    else $error("second clock fields wrong");
  chk_snoop_next: assert property (!bus_strobe_n && bus_req_type[2:1] != 2'h0
    |=> snoop_start && snoop_addr == ~$past(pins_in.addr_n))
    else $error("snoop not started");
  chk_config_load: assert property ($rose(reset_n) |=> power_on_config == ~$past(pins_in.addr_n))
    else $error("config not captured");
endmodule
bind rpad_initiator rpad_initiator_properties chk (.clk(clk), .reset_n(reset_n), .req(req),
  .req_ready(req_ready), .request_strobe_n(request_strobe_n), .pins_out(pins_out), .addr_oe(addr_oe),
  .pins_in(pins_in), .bus_strobe_n(bus_strobe_n), .bus_req_type(bus_req_type),
  .power_on_config(power_on_config), .snoop_start(snoop_start), .snoop_addr(snoop_addr));
`default_nettype wire

// [dv/rpad_bus_agent.sv]
`timescale 1ns/1ns
`default_nettype none
module rpad_bus_agent
  import rpad_pkg::*;
(
  input wire logic clk, // clock
  input wire logic reset_n, // reset
  input wire logic go, // start request
  input wire logic [4:0] kind, // type
  input wire logic [32:0] word, // first word
  input wire logic bad, // corrupt parity
  input wire logic [32:0] cfg, // config value
  output rpad_pins_t pins, // lines
  output logic oe, // driving
  output logic strobe_n, // strobe
  output logic [4:0] req_type // type
);
  logic [1:0] phase;
  logic cfg_hold;
  function automatic rpad_pins_t drive(input logic [32:0] w, input logic flip);
    drive = {~w, ~^w[32:21] ^ flip, ~^w[20:0]};
  endfunction
  // Held one edge past release so the capture edge still sees it
  always_ff @(posedge clk)
  begin
    cfg_hold <= !reset_n;
  end
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      phase <= 2'h0;
    else if (go || phase != 2'h0)
      phase <= phase + 2'h1;
  end
  assign strobe_n = phase != 2'h1;
  assign oe = cfg_hold || phase == 2'h1 || phase == 2'h2;
  assign req_type = kind;
  assign pins = cfg_hold ? drive(cfg, 1'b0) : phase == 2'h1 ? drive(word, bad) : drive(33'h0, 1'b0);
endmodule
`default_nettype wire

// [dv/rpad_initiator_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module rpad_initiator_tb_top
  import rpad_pkg::*;
;
  logic clk, reset_n, req_valid, req_ready, strobe_n, addr_oe, a_go, a_bad, a_oe, a_strobe_n;
  logic snoop_start, io_seen, reply_match, parity_error;
  rpad_req_t req;
  rpad_pins_t pins_out, a_pins, bus_pins;
  logic [4:0] a_kind, a_type, bus_type;
  logic [32:0] a_word, a_cfg, power_on_config, snoop_addr, w;
  logic [13:0] io_addr;
  logic [7:0] reply_tag;
  logic [1:0] critical_word;
  logic [4:0] types [8] = '{5'h02, 5'h04, 5'h16, 5'h10, 5'h11, 5'h09, 5'h08, 5'h18};
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  // Idle lines are pulled up, so released address reads all ones
  assign bus_pins = addr_oe ? pins_out : a_oe ? a_pins : '1;
  assign bus_type = !strobe_n ? req.req_type : a_type;
  rpad_initiator #(.TAGS(8)) uut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .request_strobe_n(strobe_n), .pins_out(pins_out), .addr_oe(addr_oe),
    .pins_in(bus_pins), .bus_strobe_n(strobe_n & a_strobe_n), .bus_req_type(bus_type),
    .power_on_config(power_on_config), .snoop_start(snoop_start), .snoop_addr(snoop_addr),
    .critical_word(critical_word), .io_seen(io_seen), .io_addr(io_addr), .reply_match(reply_match),
    .reply_tag(reply_tag), .parity_error(parity_error));
  rpad_bus_agent agent_m (.clk(clk), .reset_n(reset_n), .go(a_go), .kind(a_kind), .word(a_word),
    .bad(a_bad), .cfg(a_cfg), .pins(a_pins), .oe(a_oe), .strobe_n(a_strobe_n), .req_type(a_type));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      close_out();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic rpad_pins_t pins_of(input logic [32:0] v);
    return {~v, ~^v[32:21], ~^v[20:0]};
  endfunction
  function automatic logic [32:0] first_word(input rpad_req_t r);
    if (r.req_type[2:1] != 2'h0) return r.first_addr;
    if (r.req_type[4:1] == 4'h8) return {19'h0, r.first_addr[13:0]};
    if (r.req_type == 5'h00) return {12'h0, r.deferred_tag, 13'h0};
    return 33'h0;
  endfunction
  function automatic rpad_req_t rand_req(input logic [4:0] t, input logic [7:0] tag);
    rand_req = rpad_req_t'(67'({$urandom(), $urandom(), $urandom()}));
    rand_req.req_type = t;
    rand_req.deferred_tag = tag;
  endfunction
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic issue(input rpad_req_t r, input logic refuse);
    int n;
    logic [32:0] second;
    second = {4'h0, r.req_attributes, r.deferred_tag, r.byte_lane_enables, r.extended_function};
    tick();
    req = r;
    req_valid = 1'b1;
    n = 0;
    do
    begin
      tick();
      n++;
    end
    while (req_ready !== 1'b1 && n < 8);
    check(req_ready, !refuse);
    req_valid = 1'b0;
    if (!refuse)
    begin
      check({strobe_n, addr_oe, pins_out}, {2'b01, pins_of(first_word(r))});
      tick();
      check({strobe_n, addr_oe, pins_out}, {2'b11, pins_of(second)});
      tick();
      check(addr_oe, 1'b0);
    end
  endtask
  task automatic agent(input logic [4:0] k, input logic [32:0] v, input logic bad, input logic hit);
    logic seen_hit, seen_err;
    tick();
    {a_kind, a_word, a_bad, a_go} = {k, v, bad, 1'b1};
    tick();
    a_go = 1'b0;
    tick();
    if (k[2:1] != 2'h0) check({snoop_start, snoop_addr, critical_word}, {1'b1, v, v[1:0]});
    if (k[4:1] == 4'h8) check({io_seen, io_addr}, {1'b1, v[13:0]});
    seen_hit = reply_match;
    seen_err = parity_error;
    repeat (2)
    begin
      tick();
      seen_hit |= reply_match;
      seen_err |= parity_error;
    end
    check({seen_hit, seen_err}, {hit, bad});
    if (k == 5'h00) check(reply_tag, v[20:13]);
  endtask
  initial
  begin
    {reset_n, req_valid, req, a_go, a_kind, a_word, a_bad} = '0;
    w = 33'($urandom(5));
    a_cfg = 33'({$urandom(), $urandom()});
    repeat (12) @(posedge clk);
    #1;
    reset_n = 1'b1;
    tick();
    tick();
    check(power_on_config, a_cfg);
    for (int i = 0; i < 8; i++)
    begin
      // Tags 0..7 fill the outstanding table exactly
      req = rand_req(types[i], 8'(i));
      if (i == 0) req.first_addr = '1;
      issue(req, 1'b0);
    end
    issue(rand_req(5'h06, 8'h08), 1'b1);
    issue(rand_req(5'h00, 8'h80), 1'b0);
    agent(5'h00, {12'h0, 8'h03, 13'h0}, 1'b0, 1'b1);
    issue(rand_req(5'h06, 8'h08), 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      w = 33'({$urandom(), $urandom()});
      if (i[0]) w = {19'h0, w[13:0]};
      agent(i[0] ? 5'h10 : 5'h0a, w, i == 4, 1'b0);
    end
    agent(5'h00, {12'h0, 8'h77, 13'h0}, 1'b0, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
